// *** tti_defines.svh ***
// Constants of the teletext inserter: timing, bit counts and rate increments.
// Assumes a 250 MHz pixel-side clock; included by the design and the bench.
`ifndef TTI_DEFINES_SVH
`define TTI_DEFINES_SVH

`define TTI_CLK_PERIOD_NS 4
`define TTI_CLK_HZ 64'd250000000
// First inserted bit after the sync leading edge, in ns
`define TTI_T_TTX_PAL_NS 9780
`define TTI_T_TTX_NTSC_NS 10500
`define TTI_T_TTX_PAL_CYC ((`TTI_T_TTX_PAL_NS + `TTI_CLK_PERIOD_NS - 1) / `TTI_CLK_PERIOD_NS)
`define TTI_T_TTX_NTSC_CYC ((`TTI_T_TTX_NTSC_NS + `TTI_CLK_PERIOD_NS - 1) / `TTI_CLK_PERIOD_NS)
// Bits per insertion window
`define TTI_BITS_PAL 9'h168
`define TTI_BITS_WST 9'h128
`define TTI_BITS_NABTS 9'h120
// Text data rates in bit/s
`define TTI_RATE_PAL_HZ 64'd6937500
`define TTI_RATE_NTSC_HZ 64'd5727200
`define TTI_NCO_W 24
`define TTI_NCO_INC(r) (24'(((r) * 64'd16777216) / `TTI_CLK_HZ))
`define TTI_POS_MAX 12'hfff

`endif

// *** tti_pkg.sv ***
// Types shared by the teletext inserter.
// Constants live in tti_defines.svh.
`default_nettype none
package tti_pkg;

    typedef enum logic [1:0] {
        TTI_STD_PAL,
        TTI_STD_WST,
        TTI_STD_NABTS
    } tti_std_e;

    // Bit stream towards the composite and luminance paths
    typedef struct packed {
        logic window;
        logic data;
    } tti_ins_s;

endpackage
`default_nettype wire

// *** tti_inserter.sv ***
// Teletext inserter: requests bits from a source, buffers them, inserts them after hsync.
// Assumes hsync_lead_in is a one-cycle pulse and line/field inputs are stable over a line.
`timescale 1ns/1ns
`default_nettype none
`include "tti_defines.svh"

module tti_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out,
    output logic [$clog2(DEPTH):0] level_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic push, pop;

    assign level_out = wr_reg - rd_reg;
    assign in_ready_out = (level_out != (AW+1)'(DEPTH));
    assign out_valid_out = (level_out != '0);
    assign out_data_out = mem[rd_reg[AW-1:0]];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = pop ? rd_reg + 1'b1 : rd_reg;
        if (flush_in) begin
            wr_next = '0;
            rd_next = '0;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    // Storage needs no reset; reads are gated by the level
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data_in;
        end
    end
endmodule

module tti_inserter #(
    parameter int FIFO_DEPTH = 16,
    parameter int DELAY_MAX = 64,
    parameter int INTERP_DELAY = 8
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic hsync_lead_in,
    input wire logic field_odd_in,
    input wire logic [9:0] line_number_in,
    input wire tti_pkg::tti_std_e std_sel_in,
    input wire logic new_protocol_in,
    input wire logic insertion_enable_in,
    input wire logic [11:0] request_start_position_in,
    input wire logic [5:0] request_to_data_delay_in,
    input wire logic [9:0] odd_field_first_line_in,
    input wire logic [9:0] odd_field_last_line_in,
    input wire logic [9:0] even_field_first_line_in,
    input wire logic [9:0] even_field_last_line_in,
    input wire logic teletext_serial_in,
    output logic teletext_bit_request_out,
    output tti_pkg::tti_ins_s teletext_insert_out
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    function automatic logic [8:0] bit_total(input tti_pkg::tti_std_e s);
        if (s == tti_pkg::TTI_STD_PAL) begin
            return `TTI_BITS_PAL;
        end else if (s == tti_pkg::TTI_STD_WST) begin
            return `TTI_BITS_WST;
        end else begin
            return `TTI_BITS_NABTS;
        end
    endfunction

    function automatic logic [23:0] rate_inc(input tti_pkg::tti_std_e s);
        return (s == tti_pkg::TTI_STD_PAL) ? `TTI_NCO_INC(`TTI_RATE_PAL_HZ) : `TTI_NCO_INC(`TTI_RATE_NTSC_HZ);
    endfunction

    // Window opens early by the interpolation latency so the bit lands on time
    function automatic logic [11:0] open_pos(input tti_pkg::tti_std_e s);
        return (s == tti_pkg::TTI_STD_PAL) ? 12'(`TTI_T_TTX_PAL_CYC - INTERP_DELAY)
                                           : 12'(`TTI_T_TTX_NTSC_CYC - INTERP_DELAY);
    endfunction

    logic [11:0] pos_reg, pos_next;
    logic line_ok_reg, line_ok_next;
    logic req_active_reg, req_active_next;
    logic [8:0] req_cnt_reg, req_cnt_next;
    logic [23:0] req_acc_reg, req_acc_next;
    logic [LW-1:0] in_flight_reg, in_flight_next;
    logic [DELAY_MAX-1:0] pipe_reg, pipe_next;
    logic win_reg, win_next;
    logic [8:0] ins_cnt_reg, ins_cnt_next;
    logic [23:0] ins_acc_reg, ins_acc_next;
    logic data_reg, data_next;
    logic req_tick, ins_tick, sample_now, in_range;
    logic [24:0] req_sum, ins_sum;
    logic fifo_in_ready, fifo_out_valid, fifo_out_data;
    logic [LW-1:0] fifo_level;

    tti_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .flush_in(hsync_lead_in),
        .in_valid_in(sample_now),
        .in_ready_out(fifo_in_ready),
        .in_data_in(teletext_serial_in),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(ins_tick),
        .out_data_out(fifo_out_data),
        .level_out(fifo_level)
    );

    assign in_range = field_odd_in
        ? (line_number_in >= odd_field_first_line_in && line_number_in <= odd_field_last_line_in)
        : (line_number_in >= even_field_first_line_in && line_number_in <= even_field_last_line_in);
    assign req_sum = {1'b0, req_acc_reg} + {1'b0, rate_inc(std_sel_in)};
    assign ins_sum = {1'b0, ins_acc_reg} + {1'b0, rate_inc(std_sel_in)};
    // A request is only issued when its bit is sure to find room in the buffer
    assign req_tick = req_active_reg && req_sum[24] && (32'(fifo_level) + 32'(in_flight_reg) < FIFO_DEPTH);
    assign ins_tick = win_reg && ins_sum[24];
    assign sample_now = !hsync_lead_in && ((request_to_data_delay_in == 6'h00) ? req_tick
                        : pipe_reg[request_to_data_delay_in - 6'h01]);

    always_comb begin
        pos_next = (pos_reg == `TTI_POS_MAX) ? pos_reg : pos_reg + 12'h001;
        line_ok_next = line_ok_reg;
        req_active_next = req_active_reg;
        req_cnt_next = req_cnt_reg;
        req_acc_next = req_active_reg ? req_sum[23:0] : '0;
        pipe_next = {pipe_reg[DELAY_MAX-2:0], req_tick};
        in_flight_next = in_flight_reg + LW'(req_tick) - LW'(sample_now);
        win_next = win_reg;
        ins_cnt_next = ins_cnt_reg;
        ins_acc_next = win_reg ? ins_sum[23:0] : '0;
        data_next = data_reg;
        if (hsync_lead_in) begin
            pos_next = '0;
            line_ok_next = insertion_enable_in && in_range;
            req_active_next = 1'b0;
            req_cnt_next = '0;
            pipe_next = '0;
            in_flight_next = '0;
            win_next = 1'b0;
            ins_cnt_next = '0;
        end else begin
            if (line_ok_reg && !req_active_reg && req_cnt_reg == 9'h000 &&
                pos_reg == request_start_position_in) begin
                req_active_next = 1'b1;
            end
            if (req_tick) begin
                req_cnt_next = req_cnt_reg + 9'h001;
                if (req_cnt_next == bit_total(std_sel_in)) begin
                    req_active_next = 1'b0;
                end
            end
            if (line_ok_reg && insertion_enable_in && !win_reg && ins_cnt_reg == 9'h000 &&
                pos_reg == open_pos(std_sel_in)) begin
                win_next = 1'b1;
            end
            if (ins_tick) begin
                // An underrun inserts zero rather than stalling the line timing
                data_next = fifo_out_valid ? fifo_out_data : 1'b0;
                ins_cnt_next = ins_cnt_reg + 9'h001;
                if (ins_cnt_next == bit_total(std_sel_in)) begin
                    win_next = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pos_reg <= `TTI_POS_MAX;
            line_ok_reg <= 1'b0;
            req_active_reg <= 1'b0;
            req_cnt_reg <= '0;
            req_acc_reg <= '0;
            pipe_reg <= '0;
            in_flight_reg <= '0;
            win_reg <= 1'b0;
            ins_cnt_reg <= '0;
            ins_acc_reg <= '0;
            data_reg <= 1'b0;
        end else begin
            pos_reg <= pos_next;
            line_ok_reg <= line_ok_next;
            req_active_reg <= req_active_next;
            req_cnt_reg <= req_cnt_next;
            req_acc_reg <= req_acc_next;
            pipe_reg <= pipe_next;
            in_flight_reg <= in_flight_next;
            win_reg <= win_next;
            ins_cnt_reg <= ins_cnt_next;
            ins_acc_reg <= ins_acc_next;
            data_reg <= data_next;
        end
    end

    // New protocol pulses once per bit; old protocol holds one window
    assign teletext_bit_request_out = new_protocol_in ? req_tick : req_active_reg;
    assign teletext_insert_out.window = win_reg;
    assign teletext_insert_out.data = data_reg;

    a_window_needs_enable: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(win_reg) |-> $past(insertion_enable_in) && $past(line_ok_reg))
        else $error("Insertion window opened while disabled");

    a_window_open_time: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(win_reg) |-> $past(pos_reg) == $past(open_pos(std_sel_in)))
        else $error("Insertion window opened at wrong position");

    a_window_bit_count: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $fell(win_reg) && !$past(hsync_lead_in) |-> ins_cnt_reg == bit_total(std_sel_in))
        else $error("Insertion window closed with wrong bit count");

    a_pulse_single: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        new_protocol_in && teletext_bit_request_out |=> !teletext_bit_request_out)
        else $error("Request pulse longer than one cycle");

    a_request_start: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(req_active_reg) |-> $past(pos_reg) == $past(request_start_position_in))
        else $error("Requests started at wrong position");

    a_line_range: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(req_active_reg) |-> line_ok_reg)
        else $error("Requests on a line outside the range");

    a_old_window_count: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $fell(req_active_reg) && !$past(hsync_lead_in) |-> req_cnt_reg == bit_total(std_sel_in))
        else $error("Request window ended before full count");

    a_sample_accepted: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        sample_now |-> fifo_in_ready)
        else $error("Sampled bit found no room in the buffer");

    a_buffer_room: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        32'(fifo_level) + 32'(in_flight_reg) <= FIFO_DEPTH)
        else $error("Outstanding bits exceed buffer room");
endmodule

`default_nettype wire

// *** tti_src_model.sv ***
// Behavioural teletext source that answers the inserter's bit requests.
// Assumes requests synchronous to clk_in; a delay of 0 answers in the request's own cycle.
`timescale 1ns/1ns
`default_nettype none

module tti_src_model (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic req_in,
    input wire logic new_protocol_in,
    input wire logic [5:0] delay_in,
    output logic bit_out
);
    logic [63:0] pipe_reg;
    logic count_reg;
    logic last_reg;
    logic tap;

    // Request history, so each bit appears exactly delay_in cycles after its request
    assign tap = (delay_in == 6'h00) ? req_in : pipe_reg[delay_in - 6'h1];
    // Under the new protocol the line toggles outside a valid slot, so a wrong sample time shows up
    assign bit_out = new_protocol_in ? (tap ? ~count_reg : ~last_reg) : (req_in | tap);

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pipe_reg <= '0;
            count_reg <= 1'h0;
            last_reg <= 1'h0;
        end else begin
            pipe_reg <= {pipe_reg[62:0], req_in};
            last_reg <= bit_out;
            if (new_protocol_in && tap) begin
                count_reg <= ~count_reg;
            end
        end
    end
endmodule

`default_nettype wire

// *** tb.sv ***
// Self-checking bench of the teletext inserter and its buffer.
// Assumes tti_pkg, tti_inserter, tti_fifo and tti_src_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "tti_defines.svh"

module tb;
    logic clk_in, reset_n_in, hsync, field_odd, new_prot, en, ser, req;
    logic [9:0] line_no;
    logic [5:0] dly;
    logic [11:0] start;
    tti_pkg::tti_std_e std_sel;
    tti_pkg::tti_ins_s ins;
    int errors, cmp_count, req_rise, win_rise, data_rise, win_at, since, req_first, req_at_win;
    logic req_q, win_q, data_q;

`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin errors++; \
    $display("unexpected %s expected %0d seen %0d", n, e, s); end end

    tti_inserter dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .hsync_lead_in(hsync),
        .field_odd_in(field_odd), .line_number_in(line_no), .std_sel_in(std_sel),
        .new_protocol_in(new_prot), .insertion_enable_in(en),
        .request_start_position_in(start), .request_to_data_delay_in(dly),
        .odd_field_first_line_in(10'h00a), .odd_field_last_line_in(10'h014),
        .even_field_first_line_in(10'h12c), .even_field_last_line_in(10'h136),
        .teletext_serial_in(ser), .teletext_bit_request_out(req), .teletext_insert_out(ins));
    tti_src_model src (.clk_in(clk_in), .reset_n_in(reset_n_in), .req_in(req),
        .new_protocol_in(new_prot), .delay_in(dly), .bit_out(ser));

    initial begin
        clk_in = 1'h0;
        forever #2 clk_in = ~clk_in;
    end

    // Cycles since the edge that took hsync; read at the falling edge to stay off the race
    always @(posedge clk_in) since <= hsync ? 0 : since + 1;

    always @(negedge clk_in) begin
        if (since == 0) req_first = -1;
        if (req && !req_q) begin
            req_rise++;
            if (req_first < 0) req_first = since;
        end
        if (ins.window && !win_q) begin
            win_rise++;
            win_at = since;
            req_at_win = req_rise;
        end
        if (ins.window && ins.data && !data_q) data_rise++;
        req_q = req;
        win_q = ins.window;
        data_q = ins.data;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic run_line(input string name, input logic odd, input logic [9:0] ln,
            input tti_pkg::tti_std_e s, input logic np, input logic e, input logic [5:0] d,
            input logic [11:0] sp, input int bits, input int cut);
        int t, inc, first, r0, w0, d0;
        @(negedge clk_in);
        field_odd = odd;
        line_no = ln;
        std_sel = s;
        new_prot = np;
        en = e;
        dly = d;
        start = sp;
        r0 = req_rise;
        w0 = win_rise;
        d0 = data_rise;
        hsync = 1'h1;
        @(negedge clk_in);
        hsync = 1'h0;
        t = (s == tti_pkg::TTI_STD_PAL) ? `TTI_T_TTX_PAL_CYC : `TTI_T_TTX_NTSC_CYC;
        inc = (s == tti_pkg::TTI_STD_PAL) ? `TTI_NCO_INC(`TTI_RATE_PAL_HZ) : `TTI_NCO_INC(`TTI_RATE_NTSC_HZ);
        // First pulse comes when the rate accumulator first carries
        first = np ? int'(sp) + (16777216 + inc - 1) / inc : int'(sp) + 1;
        if (cut > 0) begin
            // Cut while the buffer is full and nothing is in flight; the next hsync must flush it
            repeat (cut) @(negedge clk_in);
            `CHK("requests before cut", 16, req_rise - r0);
            `CHK("window before cut", 1'h0, ins.window);
        end else begin
            repeat (t + 16) @(negedge clk_in);
            for (int i = 0; i < 20000 && ins.window; i++) @(negedge clk_in);
            if (ins.window) begin
                `CHK("window close", 1'h0, ins.window);
                close_out();
            end
            if (bits == 0) begin
                `CHK("request edges", 0, req_rise - r0);
                `CHK("windows", 0, win_rise - w0);
            end else begin
                `CHK("windows", 1, win_rise - w0);
                `CHK("window start", t - 8 + 1, win_at);
                `CHK("first request", first, req_first);
                `CHK("requests before window", np ? 16 : 1, req_at_win - r0);
                `CHK("request edges", np ? bits : 1, req_rise - r0);
                `CHK("bit pairs", np ? bits / 2 : 1, data_rise - d0);
                `CHK("last bit", np ? 1'(bits % 2) : 1'h1, ins.data);
            end
        end
        $display("test %s done", name);
    endtask

    initial begin
        errors = 0;
        cmp_count = 0;
        reset_n_in = 1'h0;
        {hsync, field_odd, new_prot, en} = '0;
        line_no = 10'h000;
        dly = 6'h03;
        start = 12'h064;
        std_sel = tti_pkg::TTI_STD_PAL;
        repeat (5) @(negedge clk_in);
        reset_n_in = 1'h1;
        run_line("pal_cut", 1'h1, 10'h00b, tti_pkg::TTI_STD_PAL, 1'h1, 1'h1, 6'h03, 12'h064, 360, 1500);
        run_line("pal_new_odd", 1'h1, 10'h00a, tti_pkg::TTI_STD_PAL, 1'h1, 1'h1, 6'h05, 12'h064, 360, 0);
        run_line("wst_new_even", 1'h0, 10'h136, tti_pkg::TTI_STD_WST, 1'h1, 1'h1, 6'h01, 12'h200, 296, 0);
        run_line("nabts_new", 1'h0, 10'h12c, tti_pkg::TTI_STD_NABTS, 1'h1, 1'h1, 6'h00, 12'h0c8, 288, 0);
        run_line("wst_old", 1'h1, 10'h014, tti_pkg::TTI_STD_WST, 1'h0, 1'h1, 6'h03, 12'h300, 296, 0);
        run_line("disabled", 1'h1, 10'h00c, tti_pkg::TTI_STD_PAL, 1'h1, 1'h0, 6'h03, 12'h064, 0, 0);
        run_line("odd_outside", 1'h1, 10'h015, tti_pkg::TTI_STD_PAL, 1'h1, 1'h1, 6'h03, 12'h064, 0, 0);
        run_line("even_outside", 1'h0, 10'h12b, tti_pkg::TTI_STD_PAL, 1'h1, 1'h1, 6'h03, 12'h064, 0, 0);
        close_out();
    end
endmodule

`default_nettype wire
